/* lui_irq_mask_edge.sv */
// Interrupt mask, trigger edge select and pending event logic with APB slave
//
// Function
// - Primary mask register at index 14H, read/write, all bits reset to one.
// - Primary mask bit 6 gates loopback activate code interrupt; zero enables.
// - Primary mask bit 5 gates loopback deactivate code interrupt; zero enables.
// - Primary mask bit 4 gates pattern synchronisation interrupt; zero enables.
// - Primary mask bit 3 gates transmit clock loss interrupt; zero enables.
// - Primary mask bit 2 gates line driver failure interrupt; zero enables.
// - Primary mask bit 1 gates alarm indication interrupt; zero enables.
// - Primary mask bit 0 gates loss of signal interrupt; zero enables.
// - Secondary mask register at index 15H, read/write, all bits reset to one.
// - Secondary mask bit 7 gates converter overflow interrupt; zero enables.
// - Secondary bits 6 and 5 gate jitter buffer overflow and underflow.
// - Secondary mask bit 4 gates pattern bit error interrupt; zero enables.
// - Secondary mask bit 3 gates excess zeros interrupt; zero enables.
// - Secondary mask bit 2 gates code violation interrupt; zero enables.
// - Secondary mask bit 1 gates one second tick interrupt; zero enables.
// - Secondary mask bit 0 gates counter overflow interrupt; zero enables.
// - Edge select register at index 16H resets to zero; bit 7 reserved.
// - Edge bits 6 and 5: zero rising only, one any change, loop codes.
// - Edge bit 4: zero rising only, one any change, pattern sync.
// - Edge bit 3: zero rising only, one any change, clock loss.
// - Edge bits 2 and 1: same choice for driver fail and alarm.
// - Edge bit 0: same choice for loss of signal.
// - Read-only line status at index 17H holds watched bits 6 down to 0.
// - Clock lost when transmit clock silent more than 70 master cycles.
//
// Register access over APB is this design's own decision.
`timescale 1ns/1ps

`include "lui_consts.svh"

module lui_irq_mask_edge
  import lui_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        loop_activate_seen,
  input  wire logic        loop_deactivate_seen,
  input  wire logic        pattern_sync_seen,
  input  wire logic        tx_line_clock,
  input  wire logic        driver_fail_seen,
  input  wire logic        alarm_ind_seen,
  input  wire logic        signal_loss_seen,
  input  wire logic        converter_overflow_evt,
  input  wire logic        jitter_buf_overflow_evt,
  input  wire logic        jitter_buf_underflow_evt,
  input  wire logic        pattern_error_evt,
  input  wire logic        excess_zeros_evt,
  input  wire logic        code_violation_evt,
  input  wire logic        second_tick_evt,
  input  wire logic        counter_overflow_evt,
  output logic             irq_request,
  output logic             tx_clock_lost
);

  // Register storage
  lui_byte_t      irq_mask_primary_reg;
  lui_byte_t      irq_mask_secondary_reg;
  logic [6:0]     irq_edge_select_reg;
  logic [6:0]     pend_pri_reg;
  lui_byte_t      pend_sec_reg;

  // Bus slave state
  lui_apb_state_e apb_state_reg;
  logic [31:0]    prdata_reg;
  logic           pready_reg;
  logic           pslverr_reg;
  logic           irq_reg;

  // Clock loss monitor
  logic           tx_clk_prev_reg;
  logic [6:0]     silent_cnt_reg;
  logic           tx_clock_lost_reg;
  logic           tx_clk_toggled;

  // Edge detection
  logic [6:0]     line_status_realtime;
  logic [6:0]     status_prev_reg;
  logic [6:0]     pri_event;
  lui_byte_t      sec_level;
  lui_byte_t      sec_prev_reg;
  lui_byte_t      sec_event;

  // Bus decode
  logic           access;
  logic           commit;
  logic           addr_ok;
  logic [5:0]     idx;
  logic           hit_mask_pri;
  logic           hit_mask_sec;
  logic           hit_edge_sel;
  logic           hit_status;
  logic           hit_pend_pri;
  logic           hit_pend_sec;
  logic           hit_any;
  logic           wr_lane0;
  logic [31:0]    rd_value;
  logic [6:0]     pend_pri_clr;
  lui_byte_t      pend_sec_clr;
  logic [6:0]     pend_pri_next;
  lui_byte_t      pend_sec_next;
  logic [6:0]     pend_pri_live;
  lui_byte_t      pend_sec_live;

  assign prdata        = prdata_reg;
  assign pready        = pready_reg;
  assign pslverr       = pslverr_reg;
  assign irq_request   = irq_reg;
  assign tx_clock_lost = tx_clock_lost_reg;

  // Any level change of the transmit clock restarts the silence count
  assign tx_clk_toggled = (tx_line_clock != tx_clk_prev_reg);

  // Transmit clock silence counter, saturating one past the limit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_clk_prev_reg <= 1'b0;
      silent_cnt_reg  <= 7'h00;
    end else begin
      tx_clk_prev_reg <= tx_line_clock;
      if (tx_clk_toggled) begin
        silent_cnt_reg <= 7'h00;
      end else if (silent_cnt_reg <= `LUI_TX_CLK_LOSS_CYC) begin
        silent_cnt_reg <= silent_cnt_reg + 7'h01;
      end
    end
  end

  // Loss stays up while silent; one toggle clears it two edges later
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_clock_lost_reg <= 1'b0;
    end else begin
      tx_clock_lost_reg <= (silent_cnt_reg > `LUI_TX_CLK_LOSS_CYC);
    end
  end

  // Live status, laid out as the read-only status register
  always_comb begin
    line_status_realtime = 7'h00;
    line_status_realtime[`LUI_BIT_LOOP_ACT]    = loop_activate_seen;
    line_status_realtime[`LUI_BIT_LOOP_DEACT]  = loop_deactivate_seen;
    line_status_realtime[`LUI_BIT_PAT_SYNC]    = pattern_sync_seen;
    line_status_realtime[`LUI_BIT_TX_CLK_LOST] = tx_clock_lost_reg;
    line_status_realtime[`LUI_BIT_DRV_FAIL]    = driver_fail_seen;
    line_status_realtime[`LUI_BIT_ALARM_IND]   = alarm_ind_seen;
    line_status_realtime[`LUI_BIT_SIG_LOSS]    = signal_loss_seen;
  end

  always_comb begin
    sec_level = 8'h00;
    sec_level[`LUI_BIT_CONV_OVF]  = converter_overflow_evt;
    sec_level[`LUI_BIT_JA_OVF]    = jitter_buf_overflow_evt;
    sec_level[`LUI_BIT_JA_UDF]    = jitter_buf_underflow_evt;
    sec_level[`LUI_BIT_PAT_ERR]   = pattern_error_evt;
    sec_level[`LUI_BIT_EXZ]       = excess_zeros_evt;
    sec_level[`LUI_BIT_CODE_VIOL] = code_violation_evt;
    sec_level[`LUI_BIT_SEC_TICK]  = second_tick_evt;
    sec_level[`LUI_BIT_CNT_OVF]   = counter_overflow_evt;
  end

  // Previous-cycle copies for edge detection
  // They reset low, the idle level of every source, so reset makes no false edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_prev_reg <= 7'h00;
      sec_prev_reg    <= 8'h00;
    end else begin
      status_prev_reg <= line_status_realtime;
      sec_prev_reg    <= sec_level;
    end
  end

  // Status events: rising edge always, falling edge when edge select is set
  genvar gi;
  generate
    for (gi = 0; gi < 7; gi = gi + 1) begin : g_pri
      assign pri_event[gi] =
        (line_status_realtime[gi] & ~status_prev_reg[gi]) |
        (irq_edge_select_reg[gi] & ~line_status_realtime[gi] &
         status_prev_reg[gi]);
    end
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_sec
      assign sec_event[gi] = sec_level[gi] & ~sec_prev_reg[gi];
    end
  endgenerate

  // Bus decode
  assign access   = psel & penable;
  assign commit   = access & (apb_state_reg == LUI_ST_ANSWER);
  assign addr_ok  = (paddr[1:0] == 2'b00);
  assign idx      = paddr[7:2];
  assign wr_lane0 = pwrite & pstrb[0];

  always_comb begin
    hit_mask_pri = 1'b0;
    hit_mask_sec = 1'b0;
    hit_edge_sel = 1'b0;
    hit_status   = 1'b0;
    hit_pend_pri = 1'b0;
    hit_pend_sec = 1'b0;
    if (!addr_ok) begin
      hit_mask_pri = 1'b0;
    end else if (idx == `LUI_IDX_MASK_PRI) begin
      hit_mask_pri = 1'b1;
    end else if (idx == `LUI_IDX_MASK_SEC) begin
      hit_mask_sec = 1'b1;
    end else if (idx == `LUI_IDX_EDGE_SEL) begin
      hit_edge_sel = 1'b1;
    end else if (idx == `LUI_IDX_LINE_STATUS) begin
      hit_status = 1'b1;
    end else if (idx == `LUI_IDX_PEND_PRI) begin
      hit_pend_pri = 1'b1;
    end else if (idx == `LUI_IDX_PEND_SEC) begin
      hit_pend_sec = 1'b1;
    end
  end

  assign hit_any = hit_mask_pri | hit_mask_sec | hit_edge_sel |
                   hit_status | hit_pend_pri | hit_pend_sec;

  always_comb begin
    rd_value = 32'h0000_0000;
    if (hit_mask_pri) begin
      rd_value[7:0] = irq_mask_primary_reg;
    end else if (hit_mask_sec) begin
      rd_value[7:0] = irq_mask_secondary_reg;
    end else if (hit_edge_sel) begin
      rd_value[6:0] = irq_edge_select_reg;
    end else if (hit_status) begin
      rd_value[6:0] = line_status_realtime;
    end else if (hit_pend_pri) begin
      rd_value[6:0] = pend_pri_reg;
    end else if (hit_pend_sec) begin
      rd_value[7:0] = pend_sec_reg;
    end
  end

  // Slave answers one cycle into the access phase
  // Read data and error are taken in the first access cycle; writes land with ready
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      apb_state_reg <= LUI_ST_IDLE;
      pready_reg    <= 1'b0;
      pslverr_reg   <= 1'b0;
      prdata_reg    <= 32'h0000_0000;
    end else begin
      case (apb_state_reg)
        LUI_ST_IDLE: begin
          if (access) begin
            apb_state_reg <= LUI_ST_ANSWER;
            pready_reg    <= 1'b1;
            pslverr_reg   <= ~hit_any | (pwrite & hit_status);
            prdata_reg    <= pwrite ? 32'h0000_0000 : rd_value;
          end
        end
        LUI_ST_ANSWER: begin
          apb_state_reg <= LUI_ST_IDLE;
          pready_reg    <= 1'b0;
          pslverr_reg   <= 1'b0;
          prdata_reg    <= 32'h0000_0000;
        end
        default: begin
          apb_state_reg <= LUI_ST_IDLE;
          pready_reg    <= 1'b0;
          pslverr_reg   <= 1'b0;
          prdata_reg    <= 32'h0000_0000;
        end
      endcase
    end
  end

  // Mask registers, a set bit masks its source
  // Primary bit 7 is plain storage with no source behind it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_mask_primary_reg <= `LUI_RST_MASK_PRI;
    end else if (commit && wr_lane0 && hit_mask_pri) begin
      irq_mask_primary_reg <= pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_mask_secondary_reg <= `LUI_RST_MASK_SEC;
    end else if (commit && wr_lane0 && hit_mask_sec) begin
      irq_mask_secondary_reg <= pwdata[7:0];
    end
  end

  // Edge select register; reserved bit 7 is not stored
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_edge_select_reg <= `LUI_RST_EDGE_SEL;
    end else if (commit && wr_lane0 && hit_edge_sel) begin
      irq_edge_select_reg <= pwdata[6:0];
    end
  end

  // Write-one-to-clear of pending bits
  assign pend_pri_clr = (commit && wr_lane0 && hit_pend_pri) ? pwdata[6:0] : 7'h00;
  assign pend_sec_clr = (commit && wr_lane0 && hit_pend_sec) ? pwdata[7:0] : 8'h00;

  // New unmasked events win over a clear in the same cycle
  assign pend_pri_next = (pend_pri_reg & ~pend_pri_clr) |
                         (pri_event & ~irq_mask_primary_reg[6:0]);
  assign pend_sec_next = (pend_sec_reg & ~pend_sec_clr) |
                         (sec_event & ~irq_mask_secondary_reg);

  // Pending status events
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_pri_reg <= 7'h00;
    end else begin
      pend_pri_reg <= pend_pri_next;
    end
  end

  // Pending secondary events
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_sec_reg <= 8'h00;
    end else begin
      pend_sec_reg <= pend_sec_next;
    end
  end

  // A pending bit whose source is masked again no longer counts
  assign pend_pri_live = pend_pri_next & ~irq_mask_primary_reg[6:0];
  assign pend_sec_live = pend_sec_next & ~irq_mask_secondary_reg;

  // Request also drops one cycle after the mask write lands when software masks a pending source
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= (|pend_pri_live) | (|pend_sec_live);
    end
  end

endmodule

/* lui_consts.svh */
// Register offsets, field positions, reset values and timing counts
`ifndef LUI_CONSTS_SVH
`define LUI_CONSTS_SVH

// Register indices; byte address is four times the index
`define LUI_IDX_MASK_PRI     6'h14
`define LUI_IDX_MASK_SEC     6'h15
`define LUI_IDX_EDGE_SEL     6'h16
`define LUI_IDX_LINE_STATUS  6'h17
`define LUI_IDX_PEND_PRI     6'h18
`define LUI_IDX_PEND_SEC     6'h19

// Reset values
`define LUI_RST_MASK_PRI     8'hFF
`define LUI_RST_MASK_SEC     8'hFF
`define LUI_RST_EDGE_SEL     7'h00

// Primary source positions, shared by masks, edge select and status
`define LUI_BIT_LOOP_ACT     6
`define LUI_BIT_LOOP_DEACT   5
`define LUI_BIT_PAT_SYNC     4
`define LUI_BIT_TX_CLK_LOST  3
`define LUI_BIT_DRV_FAIL     2
`define LUI_BIT_ALARM_IND    1
`define LUI_BIT_SIG_LOSS     0

// Secondary source positions
`define LUI_BIT_CONV_OVF     7
`define LUI_BIT_JA_OVF       6
`define LUI_BIT_JA_UDF       5
`define LUI_BIT_PAT_ERR      4
`define LUI_BIT_EXZ          3
`define LUI_BIT_CODE_VIOL    2
`define LUI_BIT_SEC_TICK     1
`define LUI_BIT_CNT_OVF      0

// Transmit clock silence, in master clock cycles, beyond which it is lost
`define LUI_TX_CLK_LOSS_CYC  7'h46

`endif

/* lui_pkg.sv */
// Types shared by the line unit interrupt mask and edge logic
package lui_pkg;

  typedef logic [7:0] lui_byte_t;

  typedef enum logic [1:0] {
    LUI_ST_IDLE   = 2'b01,
    LUI_ST_ANSWER = 2'b10
  } lui_apb_state_e;

endpackage

/* lui_irq_mask_edge_chk.sv */
// Port-level assertions for the interrupt mask and edge block
`timescale 1ns/1ps
module lui_irq_mask_edge_chk (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        tx_line_clock,
  input wire logic        tx_clock_lost
);
  logic [7:0] quiet_reg;
  logic       clk_prev_reg;

  // Cycles since the transmit clock was last seen to change
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      quiet_reg    <= 8'h00;
      clk_prev_reg <= 1'b0;
    end else begin
      clk_prev_reg <= tx_line_clock;
      if (tx_line_clock != clk_prev_reg) quiet_reg <= 8'h00;
      else if (quiet_reg != 8'hFF) quiet_reg <= quiet_reg + 8'h01;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_access;
    psel && penable && !pready;
  endsequence

  AST_ONE_WAIT: assert property (s_setup ##1 s_access |=> pready)
    else $error("no answer one cycle into the access phase");
  AST_READY_PULSE: assert property (pready |=> !pready)
    else $error("ready held longer than one cycle");
  AST_READY_IN_ACCESS: assert property (pready |-> psel && penable)
    else $error("ready outside an access phase");
  AST_RDATA_IDLE: assert property (!pready |-> prdata == 32'h0000_0000)
    else $error("read data not zero while idle");
  AST_RDATA_UPPER: assert property (pready |-> prdata[31:8] == 24'h00_0000)
    else $error("upper read data bits not zero");
  AST_ERR_UNMAPPED: assert property (pready && (paddr[7:2] < 6'h14 || paddr[7:2] > 6'h19
    || paddr[1:0] != 2'b00) |-> pslverr && prdata == 32'h0000_0000)
    else $error("unmapped access not refused");
  AST_ERR_STATUS_WR: assert property (pready && pwrite && paddr == 8'h5C |-> pslverr)
    else $error("write to line status not refused");
  AST_LOST_SET: assert property (quiet_reg >= 8'h4A |-> tx_clock_lost)
    else $error("clock loss not flagged after long silence");
  AST_LOST_CLEAR: assert property (quiet_reg inside {[8'h04:8'h45]} |-> !tx_clock_lost)
    else $error("clock loss flagged too early");
  AST_LOST_DROP: assert property (tx_clock_lost && tx_line_clock != $past(tx_line_clock)
    |-> ##[1:3] !tx_clock_lost)
    else $error("clock loss kept after toggle");
endmodule

bind lui_irq_mask_edge lui_irq_mask_edge_chk lui_irq_mask_edge_chk_i (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .tx_line_clock(tx_line_clock), .tx_clock_lost(tx_clock_lost)
);

/* testbench.sv */
// Self-checking bench for the interrupt mask and edge block
`timescale 1ns/1ps
module testbench;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, lost, txc, tx_run, e;
  logic [7:0]  paddr, ev, nev;
  logic [6:0]  sv, ns;
  logic [3:0]  pstrb;
  logic [31:0] pwdata, prdata, r;
  int          errors, n_checks, mp, ms, es, pp, ps;

  lui_irq_mask_edge lui_irq_mask_edge_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .loop_activate_seen(sv[6]), .loop_deactivate_seen(sv[5]),
    .pattern_sync_seen(sv[4]), .tx_line_clock(txc), .driver_fail_seen(sv[2]),
    .alarm_ind_seen(sv[1]), .signal_loss_seen(sv[0]), .converter_overflow_evt(ev[7]),
    .jitter_buf_overflow_evt(ev[6]), .jitter_buf_underflow_evt(ev[5]),
    .pattern_error_evt(ev[4]), .excess_zeros_evt(ev[3]), .code_violation_evt(ev[2]),
    .second_tick_evt(ev[1]), .counter_overflow_evt(ev[0]), .irq_request(irq),
    .tx_clock_lost(lost)
  );

  always #50 pclk = ~pclk;
  always @(posedge pclk) if (tx_run) txc <= ~txc;

  task automatic chk_data(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t data %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_flag(input logic got, input logic exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t flag %b expected %b", $time, got, exp);
    end
  endtask

  // One APB transfer, held until ready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 20) begin
      n++;
      @(posedge pclk);
    end
    chk_flag(pready, 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic xe);
    apb(1'b0, a, 32'h0000_0000);
    chk_data(r, x);
    chk_flag(e, xe);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic xe);
    apb(1'b1, a, d);
    chk_flag(e, xe);
  endtask

  task automatic results;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    #1_000_000;
    errors++;
    results();
  end

  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    {psel, penable, pwrite, txc} = 4'h0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    pstrb = 4'hF;
    sv = 7'h00;
    ev = 8'h00;
    tx_run = 1'b1;
    errors = 0;
    n_checks = 0;
    void'($urandom(35718));
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rd(8'h50, 32'h0000_00FF, 1'b0);
    rd(8'h54, 32'h0000_00FF, 1'b0);
    rd(8'h58, 32'h0000_0000, 1'b0);
    rd(8'h10, 32'h0000_0000, 1'b1);
    rd(8'h52, 32'h0000_0000, 1'b1);
    wr(8'h5C, 32'h0000_00FF, 1'b1);
    pstrb <= 4'hE;
    wr(8'h50, 32'h0000_0000, 1'b0);
    pstrb <= 4'hF;
    rd(8'h50, 32'h0000_00FF, 1'b0);
    repeat (40) begin
      mp = $urandom & 255;
      ms = $urandom & 255;
      es = $urandom & 255;
      ns = 7'($urandom) & 7'h77;
      nev = 8'($urandom);
      wr(8'h50, mp, 1'b0);
      wr(8'h54, ms, 1'b0);
      wr(8'h58, es, 1'b0);
      wr(8'h60, 32'h0000_00FF, 1'b0);
      wr(8'h64, 32'h0000_00FF, 1'b0);
      @(posedge pclk);
      chk_flag(irq, 1'b0);
      pp = ((ns & ~sv) | (es & sv & ~ns)) & ~mp & 8'h77;
      ps = nev & ~ms;
      sv <= ns;
      ev <= nev;
      @(posedge pclk);
      ev <= 8'h00;
      repeat (3) @(posedge pclk);
      chk_flag(irq, (pp | ps) != 0);
      rd(8'h60, pp, 1'b0);
      rd(8'h64, ps, 1'b0);
      rd(8'h5C, ns, 1'b0);
      rd(8'h58, es & 127, 1'b0);
      rd(8'h54, ms, 1'b0);
      rd(8'h50, mp, 1'b0);
    end
    sv <= 7'h00;
    wr(8'h50, 32'h0000_00F7, 1'b0);
    wr(8'h58, 32'h0000_0008, 1'b0);
    wr(8'h60, 32'h0000_00FF, 1'b0);
    wr(8'h64, 32'h0000_00FF, 1'b0);
    tx_run <= 1'b0;
    repeat (80) @(posedge pclk);
    chk_flag(lost, 1'b1);
    chk_flag(irq, 1'b1);
    rd(8'h60, 32'h0000_0008, 1'b0);
    rd(8'h5C, 32'h0000_0008, 1'b0);
    wr(8'h60, 32'h0000_00FF, 1'b0);
    tx_run <= 1'b1;
    repeat (4) @(posedge pclk);
    chk_flag(lost, 1'b0);
    rd(8'h60, 32'h0000_0008, 1'b0);
    results();
  end
endmodule
